//--- hw/usrt_defs.vh
// Register map, bit positions and reset values of the sync serial port
// How it works
// R01 - Either receive enable starts synchronous reception
// R02 - Data sampled on shift clock falling edge
// R03 - Single enable receives one word, then stops
// R04 - Continuous runs until cleared; continuous wins
// R05 - Last bit moves word to FIFO, flag
// R06 - Receive flag read-only, clears when FIFO empty
// R07 - Receive FIFO holds two words
// R08 - Third word into full FIFO sets overrun
// R09 - Overrun cleared only by clearing continuous enable
// R10 - Overrun blocks all transfers into FIFO
// R11 - Ninth bit queued with its word
// R12 - Software reads status before FIFO data
// R13 - Receive interrupt needs flag and enable
// R14 - Software setup order for master reception
// R15 - Clock master bit clear takes external clock
// R16 - Slave port keeps shifting during sleep
// R17 - Second word waits, transmit flag stays clear
// R18 - After shift-out reload, then set flag
// R19 - Transmit flag with enable wakes chip
// R20 - Software setup order for slave transmission
// R21 - Load ninth bit before data word
// R22 - Software sets global and peripheral enables
// R23 - Bits shift out on rising clock edge
// R24 - Transmit flag means buffer empty, write clears
// R25 - Eight data bits, optional ninth bit
`ifndef USRT_DEFS_VH
`define USRT_DEFS_VH
// Register indices; byte address is four times the index
`define USRT_IX_INTCTL 8'h0b
`define USRT_IX_PFLAG 8'h0c
`define USRT_IX_RXSC 8'h18
`define USRT_IX_TXBUF 8'h19
`define USRT_IX_RXFIFO 8'h1a
`define USRT_IX_PIEN 8'h8c
`define USRT_IX_TXSC 8'h98
`define USRT_IX_BAUD 8'h99
// Bit positions
`define USRT_B_SERIAL_PORT_ENABLE 7
`define USRT_B_RX9 6
`define USRT_B_SINGLE_RECEIVE_ENABLE 5
`define USRT_B_CONTINUOUS_RECEIVE_ENABLE 4
`define USRT_B_OVERRUN_ERROR 1
`define USRT_B_CLOCK_SOURCE_MASTER 7
`define USRT_B_TX9 6
`define USRT_B_TRANSMIT_ENABLE 5
`define USRT_B_SYNC 4
`define USRT_B_BAUD_HIGH_SPEED 2
`define USRT_B_TRANSMIT_NINTH_BIT 0
`define USRT_B_RECEIVE_FLAG 5
`define USRT_B_TRANSMIT_FLAG 4
`define USRT_B_GIE 7
`define USRT_B_PERIPHERAL_IRQ_ENABLE 6
// Reset values
`define USRT_RST_ZERO 8'h00
`define USRT_RST_TXSC 8'h02
// Index of the last bit of a word, without and with the ninth bit
`define USRT_LAST8 4'h7
`define USRT_LAST9 4'h8
`endif

//--- hw/usrt_core.v
// Synchronous serial port: master receive, slave transmit, AHB-Lite registers
`timescale 1ns/1ns
`include "usrt_defs.vh"
module usrt_core (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire serial_clock_pin_in,
   output reg serial_clock_pin_out,
   output reg serial_clock_pin_oe,
   input wire serial_data_pin_in,
   output reg serial_data_pin_out,
   output reg serial_data_pin_oe,
   output reg irq_out,
   output reg wake_out
);
   localparam C_NONE = 4'h0;
   localparam C_INTCTL = 4'h1;
   localparam C_PFLAG = 4'h2;
   localparam C_RXSC = 4'h3;
   localparam C_TXBUF = 4'h4;
   localparam C_RXFIFO = 4'h5;
   localparam C_PIEN = 4'h6;
   localparam C_TXSC = 4'h7;
   localparam C_BAUD = 4'h8;

   // =====================================================
   // Register decode
   // Shared by the read mux and the write path
   function [3:0] reg_code;
      input [7:0] idx;
      begin
         case (idx)
            `USRT_IX_INTCTL: reg_code = C_INTCTL;
            `USRT_IX_PFLAG: reg_code = C_PFLAG;
            `USRT_IX_RXSC: reg_code = C_RXSC;
            `USRT_IX_TXBUF: reg_code = C_TXBUF;
            `USRT_IX_RXFIFO: reg_code = C_RXFIFO;
            `USRT_IX_PIEN: reg_code = C_PIEN;
            `USRT_IX_TXSC: reg_code = C_TXSC;
            `USRT_IX_BAUD: reg_code = C_BAUD;
            default: reg_code = C_NONE;
         endcase
      end
   endfunction

   // Software visible state
   reg [7:0] interrupt_control;
   reg [7:0] peripheral_flags_one;
   reg [7:0] peripheral_irq_enables_one;
   reg [7:0] baud_divisor;
   reg serial_port_enable;
   reg receive_nine_bit_mode;
   reg single_receive_enable;
   reg continuous_receive_enable;
   reg overrun_error;
   reg clock_source_master;
   reg transmit_nine_bit_mode;
   reg transmit_enable;
   reg sync_mode_select;
   reg baud_high_speed;
   reg transmit_ninth_bit;
   reg [7:0] transmit_buffer_reg;
   reg tx_full;
   reg transmit_flag;
   // Bus data phase state
   reg [3:0] wr_code;
   // Pin synchronisers
   reg ck_s1;
   reg ck_s2;
   reg ck_s3;
   reg dt_s1;
   reg dt_s2;
   // Master clock generator
   reg [7:0] brg_cnt;
   // Receiver
   reg [8:0] receive_shift_reg;
   reg [3:0] rx_cnt;
   reg [8:0] rx_mem [0:1];
   reg rd_ptr;
   reg wr_ptr;
   reg [1:0] rx_fill;
   // Transmitter
   reg [8:0] transmit_shift_reg;
   reg [3:0] tx_cnt;
   reg [3:0] tx_last;
   reg tx_busy;
   reg [7:0] read_byte;
   reg next_tx_full;

   // =====================================================
   // Bus decode
   wire adr_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
   wire take = hsel & hready & htrans[1];
   wire [3:0] a_code = adr_ok ? reg_code(haddr[9:2]) : C_NONE;
   wire [7:0] wdb = hwdata[7:0];
   wire wr_rxsc = (wr_code == C_RXSC);
   wire wr_txsc = (wr_code == C_TXSC);
   wire wr_txbuf = (wr_code == C_TXBUF);

   // =====================================================
   // Mode and event decode
   wire sync_on = serial_port_enable & sync_mode_select;
   // R04 continuous wins
   // Either enable keeps the receiver running; the single one is dropped later
   wire rx_on = sync_on & (continuous_receive_enable | single_receive_enable);
   // Half duplex: receiving pauses the transmitter without resetting it
   wire tx_run = sync_on & transmit_enable & tx_busy & ~rx_on;
   wire clk_run = sync_on & clock_source_master & (rx_on | tx_run);
   wire brg_hit = (brg_cnt == baud_divisor);
   wire m_rise = clk_run & brg_hit & ~serial_clock_pin_out;
   wire m_fall = clk_run & brg_hit & serial_clock_pin_out;
   wire s_rise = ck_s2 & ~ck_s3;
   wire s_fall = ~ck_s2 & ck_s3;
   // R15 clock source select
   wire rise_ev = clock_source_master ? m_rise : s_rise;
   wire fall_ev = clock_source_master ? m_fall : s_fall;

   // R25 word length
   wire [3:0] rx_last_ix = receive_nine_bit_mode ? `USRT_LAST9 : `USRT_LAST8;
   wire rx_done = rx_on & fall_ev & (rx_cnt == rx_last_ix);
   wire [8:0] rx_word = receive_nine_bit_mode ?
      {dt_s2, receive_shift_reg[7:0]} : {1'b0, dt_s2, receive_shift_reg[6:0]};
   // R10 overrun blocks transfer
   wire rx_push = rx_done & ~overrun_error & (rx_fill != 2'h2);
   // R08 full FIFO overrun
   wire ovr_set = rx_done & ~overrun_error & (rx_fill == 2'h2);
   wire rx_pop = take & ~hwrite & (a_code == C_RXFIFO) & (rx_fill != 2'h0);
   // R06 flag tracks FIFO
   wire receive_flag = (rx_fill != 2'h0);
   wire [8:0] rx_head = rx_mem[rd_ptr];
   // Shift register takes the buffered word once the previous one is out
   wire tx_load = sync_on & transmit_enable & tx_full & ~tx_busy;

   // =====================================================
   // Pin synchronisers, two stages before any use
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ck_s1 <= 1'b0;
         ck_s2 <= 1'b0;
         ck_s3 <= 1'b0;
         dt_s1 <= 1'b0;
         dt_s2 <= 1'b0;
      end else begin
         ck_s1 <= serial_clock_pin_in;
         ck_s2 <= ck_s1;
         ck_s3 <= ck_s2;
         dt_s1 <= serial_data_pin_in;
         dt_s2 <= dt_s1;
      end
   end

   // =====================================================
   // Read mux; unmapped indices read as zero
   always @* begin
      case (a_code)
         C_INTCTL: read_byte = interrupt_control;
         C_PFLAG: read_byte = {peripheral_flags_one[7:6], receive_flag,
                               transmit_flag, peripheral_flags_one[3:0]};
         // R11 ninth bit follows head
         C_RXSC: read_byte = {serial_port_enable, receive_nine_bit_mode,
                              single_receive_enable, continuous_receive_enable,
                              2'b00, overrun_error, rx_head[8]};
         C_TXBUF: read_byte = transmit_buffer_reg;
         C_RXFIFO: read_byte = rx_head[7:0];
         C_PIEN: read_byte = peripheral_irq_enables_one;
         C_TXSC: read_byte = {clock_source_master, transmit_nine_bit_mode,
                              transmit_enable, sync_mode_select, 1'b0,
                              baud_high_speed, ~tx_busy, transmit_ninth_bit};
         C_BAUD: read_byte = baud_divisor;
         default: read_byte = 8'h00;
      endcase
   end

   // Bus slave: zero wait states, read data latched at the address phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_code <= C_NONE;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_code <= (take & hwrite) ? a_code : C_NONE;
         if (take & ~hwrite) begin
            hrdata <= {24'h000000, read_byte};
         end
      end
   end

   // =====================================================
   // Control registers and their hardware side effects
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_control <= `USRT_RST_ZERO;
         peripheral_flags_one <= `USRT_RST_ZERO;
         peripheral_irq_enables_one <= `USRT_RST_ZERO;
         baud_divisor <= `USRT_RST_ZERO;
         serial_port_enable <= 1'b0;
         receive_nine_bit_mode <= 1'b0;
         single_receive_enable <= 1'b0;
         continuous_receive_enable <= 1'b0;
         overrun_error <= 1'b0;
         clock_source_master <= 1'b0;
         transmit_nine_bit_mode <= 1'b0;
         transmit_enable <= 1'b0;
         sync_mode_select <= 1'b0;
         baud_high_speed <= 1'b0;
         transmit_ninth_bit <= 1'b0;
      end else begin
         if (wr_code == C_INTCTL) begin
            interrupt_control <= wdb;
         end
         if (wr_code == C_PFLAG) begin
            peripheral_flags_one <= wdb;
         end
         if (wr_code == C_PIEN) begin
            peripheral_irq_enables_one <= wdb;
         end
         if (wr_code == C_BAUD) begin
            baud_divisor <= wdb;
         end
         // R03 single word then stop
         if (rx_done & ~continuous_receive_enable) begin
            single_receive_enable <= 1'b0;
         end
         if (wr_rxsc) begin
            serial_port_enable <= wdb[`USRT_B_SERIAL_PORT_ENABLE];
            receive_nine_bit_mode <= wdb[`USRT_B_RX9];
            single_receive_enable <= wdb[`USRT_B_SINGLE_RECEIVE_ENABLE];
            continuous_receive_enable <= wdb[`USRT_B_CONTINUOUS_RECEIVE_ENABLE];
         end
         // R09 clearing continuous enable
         if (wr_rxsc & ~wdb[`USRT_B_CONTINUOUS_RECEIVE_ENABLE]) begin
            overrun_error <= 1'b0;
         end
         // R08 overrun sticks
         if (ovr_set) begin
            overrun_error <= 1'b1;
         end
         if (wr_txsc) begin
            clock_source_master <= wdb[`USRT_B_CLOCK_SOURCE_MASTER];
            transmit_nine_bit_mode <= wdb[`USRT_B_TX9];
            transmit_enable <= wdb[`USRT_B_TRANSMIT_ENABLE];
            sync_mode_select <= wdb[`USRT_B_SYNC];
            baud_high_speed <= wdb[`USRT_B_BAUD_HIGH_SPEED];
            transmit_ninth_bit <= wdb[`USRT_B_TRANSMIT_NINTH_BIT];
         end
      end
   end

   // =====================================================
   // Master clock: half period of baud_divisor+1 cycles, idles low
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         brg_cnt <= 8'h00;
         serial_clock_pin_out <= 1'b0;
         serial_clock_pin_oe <= 1'b0;
      end else begin
         serial_clock_pin_oe <= sync_on & clock_source_master;
         if (!clk_run) begin
            brg_cnt <= 8'h00;
            serial_clock_pin_out <= 1'b0;
         end else if (brg_hit) begin
            brg_cnt <= 8'h00;
            serial_clock_pin_out <= ~serial_clock_pin_out;
         end else begin
            brg_cnt <= brg_cnt + 8'h01;
         end
      end
   end

   // =====================================================
   // Receiver shift register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         receive_shift_reg <= 9'h000;
         rx_cnt <= 4'h0;
      end else if (!rx_on) begin
         rx_cnt <= 4'h0;
      end else if (fall_ev) begin
         // R02 sample on falling edge
         receive_shift_reg[rx_cnt] <= dt_s2;
         // R01 reception runs
         rx_cnt <= rx_done ? 4'h0 : rx_cnt + 4'h1;
      end
   end

   // Two entry receive FIFO; a pop of an empty FIFO changes nothing
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_mem[0] <= 9'h000;
         rx_mem[1] <= 9'h000;
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
         rx_fill <= 2'h0;
      end else begin
         // R05 word into FIFO
         if (rx_push) begin
            rx_mem[wr_ptr] <= rx_word;
            wr_ptr <= ~wr_ptr;
         end
         // R11 pop advances ninth bit
         if (rx_pop) begin
            rd_ptr <= ~rd_ptr;
         end
         // R07 two deep
         rx_fill <= rx_fill + {1'b0, rx_push} - {1'b0, rx_pop};
      end
   end

   // =====================================================
   // Buffer full flag next value; a same-cycle write keeps it full
   always @* begin
      next_tx_full = wr_txbuf | (tx_full & ~tx_load);
   end

   // Transmit buffer and flag
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         transmit_buffer_reg <= `USRT_RST_ZERO;
         tx_full <= 1'b0;
         transmit_flag <= 1'b0;
      end else begin
         if (wr_txbuf) begin
            transmit_buffer_reg <= wdb;
         end
         tx_full <= next_tx_full;
         // R24 flag mirrors empty buffer
         // R17 buffered word keeps flag clear
         transmit_flag <= ~next_tx_full;
      end
   end

   // Transmit shift register; dropping the enable resets it mid word
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         transmit_shift_reg <= 9'h000;
         tx_cnt <= 4'h0;
         tx_last <= `USRT_LAST8;
         tx_busy <= 1'b0;
         serial_data_pin_out <= 1'b0;
      end else if (!transmit_enable) begin
         tx_busy <= 1'b0;
         tx_cnt <= 4'h0;
      end else if (tx_load) begin
         // R18 reload from buffer
         // R21 ninth bit taken now
         transmit_shift_reg <= {transmit_ninth_bit, transmit_buffer_reg};
         tx_last <= transmit_nine_bit_mode ? `USRT_LAST9 : `USRT_LAST8;
         tx_cnt <= 4'h0;
         tx_busy <= 1'b1;
      end else if (tx_run & rise_ev & (tx_cnt <= tx_last)) begin
         // R23 shift on rising edge
         serial_data_pin_out <= transmit_shift_reg[tx_cnt];
         tx_cnt <= tx_cnt + 4'h1;
      end else if (tx_run & fall_ev & (tx_cnt > tx_last)) begin
         // R16 runs on external clock
         tx_busy <= 1'b0;
      end
   end

   // =====================================================
   // Data pin direction and interrupt outputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         serial_data_pin_oe <= 1'b0;
         irq_out <= 1'b0;
         wake_out <= 1'b0;
      end else begin
         // Receiving releases the data line even with transmit enabled
         serial_data_pin_oe <= sync_on & transmit_enable & ~rx_on;
         // R13 receive request gating
         // R19 transmit flag wakes chip
         wake_out <= (receive_flag & peripheral_irq_enables_one[`USRT_B_RECEIVE_FLAG]) |
                     (transmit_flag & peripheral_irq_enables_one[`USRT_B_TRANSMIT_FLAG]);
         irq_out <= interrupt_control[`USRT_B_GIE] & interrupt_control[`USRT_B_PERIPHERAL_IRQ_ENABLE] &
                    ((receive_flag & peripheral_irq_enables_one[`USRT_B_RECEIVE_FLAG]) |
                     (transmit_flag & peripheral_irq_enables_one[`USRT_B_TRANSMIT_FLAG]));
      end
   end

endmodule

//--- tb/usrt_core_asserts.sv
// Concurrent checks on the sync serial port's bus and pin behaviour
`timescale 1ns/1ns
module usrt_core_asserts (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   input wire serial_clock_pin_in,
   input wire serial_clock_pin_out,
   input wire serial_clock_pin_oe,
   input wire serial_data_pin_out,
   input wire serial_data_pin_oe,
   input wire irq_out,
   input wire wake_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // ==========================================
   // Steps shared by the properties
   sequence s_rd_req;
      hsel && hready && htrans[1] && !hwrite;
   endsequence
   // Slave transmit with the outside clock held low, i.e. after a falling edge
   sequence s_slave_low3;
      (serial_data_pin_oe && !serial_clock_pin_oe && !serial_clock_pin_in) [*3];
   endsequence
   // ==========================================
   // Bus slave
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("slave response not OKAY");
   a_zero_wait: assert property (s_rd_req |=> hreadyout)
      else $error("read answered with wait state");
   a_rdata_upper: assert property (s_rd_req |=> hrdata[31:8] == 24'h0)
      else $error("read data upper lanes not zero");
   a_rdata_holds: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
      else $error("read data moved without a read");
   // ==========================================
   // Pins and interrupt outputs
   a_irq_gated: assert property (irq_out |-> wake_out)
      else $error("interrupt without flag and enable");
   a_slave_shift_rise: assert property ((serial_data_pin_oe && !serial_clock_pin_oe
      && $changed(serial_data_pin_out)) |-> serial_clock_pin_in)
      else $error("slave data changed off a rising clock");
   a_slave_hold_fall: assert property (s_slave_low3 |=> $stable(serial_data_pin_out))
      else $error("slave data moved while clock low");
   a_clk_owned: assert property ($changed(serial_clock_pin_out) |-> $past(serial_clock_pin_oe))
      else $error("shift clock toggled while not driven");
endmodule
bind usrt_core usrt_core_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .serial_clock_pin_in(serial_clock_pin_in),
   .serial_clock_pin_out(serial_clock_pin_out), .serial_clock_pin_oe(serial_clock_pin_oe),
   .serial_data_pin_out(serial_data_pin_out), .serial_data_pin_oe(serial_data_pin_oe),
   .irq_out(irq_out), .wake_out(wake_out));

//--- tb/usrt_peer.sv
// Behavioural far-side serial device: feeds master reception, clocks slave transmission
`timescale 1ns/1ns
module usrt_peer (
   input wire ck_pin,
   input wire dt_pin,
   input wire rx_mode,
   input wire clk_run,
   input wire nine,
   input wire [8:0] feed_word,
   output logic pk,
   output logic pd,
   output logic pd_oe,
   output logic [8:0] got_word,
   output int got_count,
   output int words_started
);
   int cnt = 0;
   logic [8:0] sh = 9'h0;
   logic [8:0] acc = 9'h0;
   initial begin
      pk = 1'b0;
      pd = 1'b0;
      pd_oe = 1'b0;
      got_word = 9'h0;
   end
   // ==========================================
   // Master reception feed
   // new bit on each rising clock, LSB first, ninth last
   always @(posedge ck_pin) begin
      if (rx_mode) begin
         if (cnt == 0) begin
            sh = feed_word;
            words_started++;
         end
         pd = sh[cnt];
         pd_oe = 1'b1;
         cnt = (cnt == (nine ? 8 : 7)) ? 0 : cnt + 1;
      end
   end
   // Release the line and restart the count, so a cut word never skews the next
   always @(negedge rx_mode) begin
      pd_oe = 1'b0;
      cnt = 0;
   end
   // ==========================================
   // Slave transmission clock
   // far side owns the clock, samples at the fall, idles low between words
   initial begin
      forever begin
         wait (clk_run);
         repeat (nine ? 9 : 8) begin
            #63 pk = 1'b1;
            #62 pk = 1'b0;
            acc = {dt_pin, acc[8:1]};
         end
         got_word = nine ? acc : {1'b0, acc[8:1]};
         got_count++;
         #20;
      end
   end
endmodule

//--- tb/usart_sync_rx_and_slave_tx_tb.sv
// Self-checking bench for the sync serial port: registers, slave transmit, master receive
`timescale 1ns/1ns
`include "usrt_defs.vh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin mismatches++; \
   $display("BAD %s expected %h seen %h", nm, e, s); end end
module usart_sync_rx_and_slave_tx_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic rx_mode = 1'b0;
   logic clk_run = 1'b0;
   logic nine = 1'b0;
   logic [8:0] feed = 9'h0;
   logic idle_pat = 1'b0;
   logic rd_live = 1'b0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, ck_out, ck_oe, dt_out, dt_oe, irq_out, wake_out, pk, pd, pd_oe;
   wire [8:0] got_word;
   int got_count, words_started, base;
   int mismatches = 0;
   int n_compared = 0;
   logic [7:0] exp_q[$];
   string nm_q[$];
   logic [8:0] tx_q[$];
   logic [8:0] w[4];
   logic [8:0] te;
   logic [31:0] re;
   string rn;
   logic [7:0] rix[9] = '{`USRT_IX_INTCTL, `USRT_IX_PFLAG, `USRT_IX_RXSC, `USRT_IX_TXBUF,
      `USRT_IX_RXFIFO, `USRT_IX_PIEN, `USRT_IX_TXSC, `USRT_IX_BAUD, 8'h1b};
   logic [7:0] rexp[9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
   // Released data line shows a changing pattern, never the last driven bit
   wire ck_pin = ck_oe ? ck_out : pk;
   wire dt_pin = dt_oe ? dt_out : (pd_oe ? pd : idle_pat);

   usrt_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .serial_clock_pin_in(ck_pin),
      .serial_clock_pin_out(ck_out), .serial_clock_pin_oe(ck_oe), .serial_data_pin_in(dt_pin),
      .serial_data_pin_out(dt_out), .serial_data_pin_oe(dt_oe), .irq_out(irq_out),
      .wake_out(wake_out));
   usrt_peer u_peer (.ck_pin(ck_pin), .dt_pin(dt_pin), .rx_mode(rx_mode), .clk_run(clk_run),
      .nine(nine), .feed_word(feed), .pk(pk), .pd(pd), .pd_oe(pd_oe), .got_word(got_word),
      .got_count(got_count), .words_started(words_started));

   always #2 hclk = ~hclk;
   always @(posedge hclk) idle_pat <= ~idle_pat;

   // ==========================================
   // AHB-Lite single word transfer; a read notes its expected byte
   task bus(input logic wr, input logic [7:0] ix, input logic [7:0] d, input string nm);
      htrans <= 2'b10;
      haddr <= {22'h0, ix, 2'b00};
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      if (!wr) begin
         exp_q.push_back(d);
         nm_q.push_back(nm);
      end
      rd_live <= !wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd_live <= 1'b0;
   endtask

   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // Oldest read note is compared when a read data phase completes
   always @(posedge hclk) begin
      if (rd_live && hreadyout) begin
         re = {24'h0, exp_q.pop_front()};
         rn = nm_q.pop_front();
         `CHK(rn, re, hrdata)
      end
   end
   // Oldest transmitted word is compared when the far side has collected one
   always @(got_count) begin
      te = tx_q.pop_front();
      `CHK("serial word", te, got_word)
   end

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(32'h1f156156));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 9; i++) bus(1'b0, rix[i], rexp[i], "reset value");
      for (int i = 0; i < 4; i++) w[i] = 9'($urandom);
      bus(1'b1, 8'h1b, w[0][7:0], "");
      bus(1'b0, 8'h1b, 8'h00, "unmapped");
      bus(1'b1, `USRT_IX_BAUD, w[1][7:0], "");
      bus(1'b0, `USRT_IX_BAUD, w[1][7:0], "baud");
      $display("test registers done");
      // Slave transmit, two words queued before the clock runs
      // slave transmit setup
      bus(1'b1, `USRT_IX_RXSC, 8'h80, "");
      bus(1'b1, `USRT_IX_TXSC, 8'h50, "");
      bus(1'b1, `USRT_IX_PIEN, 8'h10, "");
      bus(1'b1, `USRT_IX_INTCTL, 8'hc0, "");
      nine <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, `USRT_IX_TXSC, {7'h38, w[i][8]}, "");
         bus(1'b1, `USRT_IX_TXBUF, w[i][7:0], "");
         tx_q.push_back(w[i]);
      end
      bus(1'b0, `USRT_IX_PFLAG, 8'h00, "flags two loaded");
      `CHK("wake early", 1'b0, wake_out)
      clk_run <= 1'b1;
      wait (wake_out === 1'b1);
      #1;
      `CHK("words out", 1, got_count)
      `CHK("irq tx", 1'b1, irq_out)
      @(posedge hclk);
      bus(1'b0, `USRT_IX_PFLAG, 8'h10, "flags reload");
      wait (got_count == 2);
      @(posedge hclk);
      clk_run <= 1'b0;
      bus(1'b1, `USRT_IX_TXSC, 8'h00, "");
      $display("test slave transmit done");
      // Continuous master receive into a full FIFO
      for (int i = 0; i < 4; i++) w[i] = 9'($urandom);
      bus(1'b1, `USRT_IX_BAUD, 8'h03, "");
      bus(1'b1, `USRT_IX_TXSC, 8'h90, "");
      bus(1'b1, `USRT_IX_PIEN, 8'h20, "");
      feed <= w[0];
      rx_mode <= 1'b1;
      base = words_started;
      bus(1'b1, `USRT_IX_RXSC, 8'hc0, "");
      bus(1'b1, `USRT_IX_RXSC, 8'hd0, "");
      bus(1'b1, `USRT_IX_RXSC, 8'hf0, "");
      for (int i = 1; i < 4; i++) begin
         wait (words_started == base + i);
         @(posedge hclk);
         feed <= w[i];
      end
      wait (words_started == base + 4);
      @(posedge hclk);
      `CHK("irq rx", 1'b1, irq_out)
      bus(1'b0, `USRT_IX_RXSC, {7'h79, w[0][8]}, "status one");
      bus(1'b0, `USRT_IX_RXFIFO, w[0][7:0], "fifo one");
      bus(1'b0, `USRT_IX_RXSC, {7'h79, w[1][8]}, "status two");
      bus(1'b0, `USRT_IX_RXFIFO, w[1][7:0], "fifo two");
      wait (words_started == base + 6);
      @(posedge hclk);
      bus(1'b0, `USRT_IX_PFLAG, 8'h10, "flags blocked");
      bus(1'b1, `USRT_IX_RXSC, 8'h80, "");
      $display("test continuous receive done");
      // Single word receive after the overrun was cleared
      nine <= 1'b0;
      rx_mode <= 1'b0;
      @(posedge hclk);
      rx_mode <= 1'b1;
      feed <= w[3];
      base = words_started;
      bus(1'b1, `USRT_IX_RXSC, 8'ha0, "");
      wait (irq_out === 1'b1);
      @(posedge hclk);
      bus(1'b0, `USRT_IX_RXSC, 8'h80, "single status");
      bus(1'b0, `USRT_IX_RXFIFO, w[3][7:0], "single word");
      repeat (100) @(posedge hclk);
      `CHK("words after single", base + 1, words_started)
      $display("test single receive done");
      tally_and_finish;
   end

   // Cut a hang short well beyond the expected run of about 5 us
   initial begin
      #100000;
      mismatches++;
      tally_and_finish;
   end
endmodule
